/* pkg/hmr_pkg.sv */
// Package for the monitor host register interface: offsets, reset values, types
package hmr_pkg;
    // Parallel port selectors (low three address bits)
    localparam logic [2:0] PORT_CODE_A  = 3'h0;
    localparam logic [2:0] PORT_CODE_B  = 3'h4;
    localparam logic [2:0] PORT_INDEX   = 3'h5;
    localparam logic [2:0] PORT_DATA    = 3'h6;
    // Internal register indices
    localparam logic [6:0] IDX_CODE_TOP = 7'h1F;
    localparam logic [6:0] IDX_RES_BASE = 7'h20;
    localparam logic [6:0] IDX_CTRL     = 7'h40;
    localparam logic [6:0] IDX_EVT_LO   = 7'h41;
    localparam logic [6:0] IDX_EVT_HI   = 7'h42;
    localparam logic [6:0] IDX_MGM_LO   = 7'h43;
    localparam logic [6:0] IDX_MGM_HI   = 7'h44;
    localparam logic [6:0] IDX_SEC_LO   = 7'h45;
    localparam logic [6:0] IDX_SEC_HI   = 7'h46;
    localparam logic [6:0] IDX_FANDIV   = 7'h47;
    localparam logic [6:0] IDX_SADDR    = 7'h48;
    localparam logic [6:0] IDX_IDENT    = 7'h49;
    localparam logic [6:0] IDX_MIR_BASE = 7'h60;
    localparam logic [6:0] IDX_MIR_TOP  = 7'h7F;
    // Reset values
    localparam logic [7:0] RST_CTRL     = 8'h08;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_SEC_HI   = 8'h40;
    localparam logic [3:0] RST_FANDIV   = 4'h5;
    localparam logic [6:0] RST_SADDR    = 7'h2D;
    // Control register bit positions
    localparam int CB_START  = 0;
    localparam int CB_MGM_EN = 1;
    localparam int CB_SEC_EN = 2;
    localparam int CB_CLR    = 3;
    localparam int CB_POL    = 5;
    localparam int CB_BYPASS = 6;
    localparam int CB_INIT   = 7;
    // Monitoring sequence
    localparam logic [3:0] SEQ_ITEMS    = 4'hB;
    localparam int         ITEM_TIME_MS = 90;
    localparam int         CLK_HZ       = 20000000;
    localparam int         ITEM_CYCLES  = (CLK_HZ / 1000) * ITEM_TIME_MS;

    // Parallel bus request
    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [2:0] addr;
        logic [7:0] wdata;
    } hmr_pbus_type;

    // Serial slave states
    typedef enum logic [2:0] {
        SS_IDLE = 3'b000,
        SS_ADDR = 3'b001,
        SS_AACK = 3'b010,
        SS_RECV = 3'b011,
        SS_RACK = 3'b100,
        SS_SEND = 3'b101,
        SS_MACK = 3'b110
    } hmr_sstate_type;
endpackage

/* hw/hmr_top.sv */
// Host register interface of the system monitor: parallel port, serial slave, map
//Contract
//- Index bit 7 read-only serial busy flag
//- Power-on values for control, flags, masks
//- First of register pair advances to second
//- Code memory with two capped pointers
//- Mirror window advances index, stops 7Fh
//- Serial read direct or after index write
//- Serial accesses never advance index
//- Serial address reset only at power-on
//- Control bit 7 soft init, self-clears
//- Soft init keeps memories untouched
//- Bit 0 runs loop, low is shutdown
//- Bits 1,2 enable the interrupt outputs
//- Bit 5 sets second output polarity
//- Bypass bit pulls open-drain output low
//- Clear bit holds interrupt outputs, stops converter
//- Eleven items measured in fixed order
//- Read aborts and restarts conversion
//- Divisor high nibble, id inputs low
//- Identity bit 7 fixed, bit 0 input
//- Three address bits, chip select low
`timescale 1ns/10ps
module hmr_top
    import hmr_pkg::*;
#(
    parameter int          ITEM_CYC = ITEM_CYCLES,
    parameter logic        ID_BIT   = 1'b0  // Arbitrary identity value
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Parallel port
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    output logic            rdata_oe,
    // Serial bus
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Identification inputs
    input  wire logic [3:0] id_voltage_bits_low,
    input  wire logic       id_voltage_bit4,
    // Monitor events and outputs
    input  wire logic [15:0] event_in,
    output logic            mgmt_irq_n,
    output logic            second_irq,
    output logic            bypass_out,
    output logic            bypass_oe,
    output logic            conv_run,
    output logic [3:0]      conv_item,
    // Result writeback from converter
    input  wire logic       res_we,
    input  wire logic [7:0] res_data
);
    // Synchronisers for pins
    hmr_pbus_type pb_s1_q, pb_s2_q, pb_s3_q;
    logic [2:0]   sr_s1_q, sr_s2_q, sr_s3_q;
    logic [4:0]   id_s1_q, id_s2_q;
    always_ff @(posedge clk) begin
        pb_s1_q <= '{cs_n, rd_n, wr_n, addr, wdata};
        pb_s2_q <= pb_s1_q;
        pb_s3_q <= pb_s2_q;
        sr_s1_q <= {scl, sda_in, 1'b0};
        sr_s2_q <= sr_s1_q;
        sr_s3_q <= sr_s2_q;
        id_s1_q <= {id_voltage_bit4, id_voltage_bits_low};
        id_s2_q <= id_s1_q;
    end

    // Parallel strobe edges on the synchronised copy
    wire sel      = ~pb_s2_q.cs_n;
    wire wr_pulse = sel & ~pb_s2_q.wr_n & pb_s3_q.wr_n;
    wire rd_pulse = sel & ~pb_s2_q.rd_n & pb_s3_q.rd_n;
    wire rd_level = sel & ~pb_s2_q.rd_n;
    wire [2:0] pa = pb_s2_q.addr;
    wire [7:0] pd = pb_s2_q.wdata;

    // Serial edges
    wire scl_s   = sr_s2_q[2];
    wire sda_s   = sr_s2_q[1];
    wire scl_r   = scl_s & ~sr_s3_q[2];
    wire scl_f   = ~scl_s & sr_s3_q[2];
    wire s_start = scl_s & sr_s3_q[2] & ~sda_s & sr_s3_q[1];
    wire s_stop  = scl_s & sr_s3_q[2] & sda_s & ~sr_s3_q[1];

    // Register state
    logic [6:0] index_q;
    logic [7:0] ctrl_q, evt_lo_q, evt_hi_q, mgm_lo_q, mgm_hi_q, sec_lo_q, sec_hi_q;
    logic [3:0] fandiv_q;
    logic [6:0] saddr_q;
    logic [4:0] code_wp_q, code_rp_q;
    logic [7:0] code_mem [0:31];
    // Results and limits; the upper window aliases the same 32 bytes
    logic [7:0] val_mem  [0:31];

    // Serial slave state
    hmr_sstate_type ss_q;
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic       rw_q, got_idx_q, busy_q;
    logic [7:0] tx_q;

    // Serial decisions
    wire byte_done   = scl_r & (bit_q == 4'h7);
    wire [7:0] sh_n  = {sh_q[6:0], sda_s};
    wire addr_match  = (sh_n[7:1] == saddr_q);
    wire s_wr_byte   = (ss_q == SS_RECV) & byte_done;
    wire s_set_index = s_wr_byte & ~got_idx_q;
    wire s_wr_data   = s_wr_byte & got_idx_q;
    wire s_read      = (ss_q == SS_ADDR) & byte_done & addr_match & sh_n[0];

    // Parallel decisions; data access acts on the index held in index_q
    wire p_wr_idx   = wr_pulse & (pa == PORT_INDEX);
    wire p_wr_data  = wr_pulse & (pa == PORT_DATA);
    wire p_rd_data  = rd_pulse & (pa == PORT_DATA);
    wire p_data     = p_wr_data | p_rd_data;
    wire p_code_wr  = wr_pulse & ((pa == PORT_CODE_A) | (pa == PORT_CODE_B));
    wire pair_first = (index_q == IDX_EVT_LO) | (index_q == IDX_MGM_LO) |
                      (index_q == IDX_SEC_LO);
    wire in_mirror  = (index_q >= IDX_MIR_BASE) & (index_q != IDX_MIR_TOP);
    wire in_code    = (index_q <= IDX_CODE_TOP);

    // Shared register write port: either interface
    wire        any_wr = p_wr_data | s_wr_data;
    wire [7:0]  wd     = p_wr_data ? pd : sh_n;
    wire        soft_init = any_wr & (index_q == IDX_CTRL) & wd[CB_INIT];

    // Read mux for the current index
    logic [7:0] rd_val;
    always_comb begin
        rd_val = RST_ZERO;
        case (index_q)
            IDX_CTRL:   rd_val = ctrl_q;
            IDX_EVT_LO: rd_val = evt_lo_q;
            IDX_EVT_HI: rd_val = evt_hi_q;
            IDX_MGM_LO: rd_val = mgm_lo_q;
            IDX_MGM_HI: rd_val = mgm_hi_q;
            IDX_SEC_LO: rd_val = sec_lo_q;
            IDX_SEC_HI: rd_val = sec_hi_q;
            IDX_FANDIV: rd_val = {fandiv_q, id_s2_q[3:0]};
            IDX_SADDR:  rd_val = {1'b0, saddr_q};
            IDX_IDENT:  rd_val = {ID_BIT, 6'h00, id_s2_q[4]};
            default: begin
                if (in_code)
                    rd_val = code_mem[code_rp_q];
                else if (index_q >= IDX_RES_BASE && index_q < IDX_CTRL)
                    rd_val = val_mem[index_q[4:0]];
                else if (index_q >= IDX_MIR_BASE)
                    rd_val = val_mem[index_q[4:0]];
                else
                    rd_val = RST_ZERO;
            end
        endcase
    end

    // Index register: parallel or serial index writes, and auto-advance
    // Serial frames load it from the index byte and never advance it
    always_ff @(posedge clk) begin
        if (rst)
            index_q <= 7'h00;
        else if (s_set_index)
            index_q <= sh_n[6:0];
        else if (p_wr_idx)
            index_q <= pd[6:0];
        else if (p_data && (pair_first || in_mirror))
            index_q <= index_q + 7'h01;
    end

    // Control, flags and masks; soft init reloads, serial address untouched
    always_ff @(posedge clk) begin
        if (rst || soft_init) begin
            ctrl_q   <= RST_CTRL;
            evt_lo_q <= RST_ZERO;
            evt_hi_q <= RST_ZERO;
            mgm_lo_q <= RST_ZERO;
            mgm_hi_q <= RST_ZERO;
            sec_lo_q <= RST_ZERO;
            sec_hi_q <= RST_SEC_HI;
            fandiv_q <= RST_FANDIV;
        end else begin
            if (any_wr && index_q == IDX_CTRL) ctrl_q <= {1'b0, wd[6:0]};
            if (any_wr && index_q == IDX_MGM_LO) mgm_lo_q <= wd;
            if (any_wr && index_q == IDX_MGM_HI) mgm_hi_q <= wd;
            if (any_wr && index_q == IDX_SEC_LO) sec_lo_q <= wd;
            if (any_wr && index_q == IDX_SEC_HI) sec_hi_q <= wd;
            if (any_wr && index_q == IDX_FANDIV) fandiv_q <= wd[7:4];
            // Sticky flags; a new event wins over the read-clear
            evt_lo_q <= ((p_rd_data && index_q == IDX_EVT_LO) ? RST_ZERO : evt_lo_q)
                        | (ctrl_q[CB_CLR] ? RST_ZERO : event_in[7:0]);
            evt_hi_q <= ((p_rd_data && index_q == IDX_EVT_HI) ? RST_ZERO : evt_hi_q)
                        | (ctrl_q[CB_CLR] ? RST_ZERO : event_in[15:8]);
        end
    end

    // Serial address: power-on reset only
    always_ff @(posedge clk) begin
        if (rst)
            saddr_q <= RST_SADDR;
        else if (any_wr && index_q == IDX_SADDR)
            saddr_q <= wd[6:0];
    end

    // Memories are never cleared by either reset
    always_ff @(posedge clk) begin
        if (p_code_wr)
            code_mem[code_wp_q] <= pd;
        if (any_wr && in_code)
            code_mem[code_rp_q] <= wd;
        // Converter write wins; a host write in the same cycle is lost
        if (res_we)
            val_mem[{1'b0, conv_item}] <= res_data;
        else if (any_wr && index_q >= IDX_RES_BASE && index_q < IDX_CTRL)
            val_mem[index_q[4:0]] <= wd;
        else if (any_wr && index_q >= IDX_MIR_BASE)
            val_mem[index_q[4:0]] <= wd;
    end

    // Code memory pointers saturate at the top entry
    always_ff @(posedge clk) begin
        if (rst) begin
            code_wp_q <= 5'h00;
            code_rp_q <= 5'h00;
        end else begin
            if (p_code_wr && code_wp_q != IDX_CODE_TOP[4:0])
                code_wp_q <= code_wp_q + 5'h01;
            if (p_data && in_code && code_rp_q != IDX_CODE_TOP[4:0])
                code_rp_q <= code_rp_q + 5'h01;
        end
    end

    // Parallel read data; driven while read strobe held
    // Captured on the strobe edge, since the index may advance right after it
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata    <= RST_ZERO;
            rdata_oe <= 1'b0;
        end else begin
            if (rd_pulse)
                rdata <= (pa == PORT_INDEX) ? {busy_q, index_q} : rd_val;
            rdata_oe <= rd_level & ((pa == PORT_INDEX) | (pa == PORT_DATA));
        end
    end

    // Serial slave machine
    always_ff @(posedge clk) begin
        if (rst) begin
            ss_q <= SS_IDLE;
            sh_q <= RST_ZERO;
            bit_q <= 4'h0;
            rw_q <= 1'b0;
            got_idx_q <= 1'b0;
            busy_q <= 1'b0;
            tx_q <= RST_ZERO;
            sda_oe <= 1'b0;
        end else if (s_stop) begin
            ss_q <= SS_IDLE;
            busy_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (s_start) begin
            ss_q <= SS_ADDR;
            bit_q <= 4'h0;
            got_idx_q <= 1'b0;
            busy_q <= 1'b1;
            sda_oe <= 1'b0;
        end else begin
            case (ss_q)
                SS_ADDR, SS_RECV: begin
                    if (scl_r) begin
                        sh_q <= sh_n;
                        bit_q <= bit_q + 4'h1;
                    end
                    if (byte_done) begin
                        bit_q <= 4'h0;
                        if (ss_q == SS_ADDR && !addr_match) begin
                            ss_q <= SS_IDLE;
                            busy_q <= 1'b0;
                        end else begin
                            ss_q <= (ss_q == SS_ADDR) ? SS_AACK : SS_RACK;
                            if (ss_q == SS_ADDR) rw_q <= sh_n[0];
                            if (ss_q == SS_RECV) got_idx_q <= 1'b1;
                            tx_q <= rd_val;
                        end
                    end
                end
                SS_AACK, SS_RACK: begin
                    if (scl_f && !sda_oe)
                        sda_oe <= 1'b1;                              // Ack low
                    else if (scl_f && sda_oe) begin
                        sda_oe <= (ss_q == SS_AACK && rw_q) ? ~tx_q[7] : 1'b0;
                        ss_q <= (ss_q == SS_AACK && rw_q) ? SS_SEND : SS_RECV;
                    end
                end
                SS_SEND: begin
                    if (scl_f) begin
                        bit_q <= bit_q + 4'h1;
                        tx_q <= {tx_q[6:0], 1'b1};
                        sda_oe <= (bit_q == 4'h7) ? 1'b0 : ~tx_q[6];
                        if (bit_q == 4'h7) ss_q <= SS_MACK;
                    end
                end
                SS_MACK: begin
                    if (scl_r) begin
                        tx_q <= rd_val;
                        bit_q <= 4'h0;
                        ss_q <= sda_s ? SS_IDLE : SS_MACK;
                    end
                end
                default: ss_q <= SS_IDLE;
            endcase
        end
    end

    // Monitoring sequencer; a data-port or serial read restarts the current item
    logic [31:0] tick_q;
    wire run = ctrl_q[CB_START] & ~ctrl_q[CB_CLR];
    wire any_read = p_rd_data | s_read;
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_q    <= 32'h0;
            conv_item <= 4'h0;
            conv_run  <= 1'b0;
        end else begin
            conv_run <= run;
            if (!run || any_read)
                tick_q <= 32'h0;
            else if (tick_q == 32'(ITEM_CYC - 1)) begin
                tick_q <= 32'h0;
                conv_item <= (conv_item == SEQ_ITEMS - 4'h1) ? 4'h0 : conv_item + 4'h1;
            end else
                tick_q <= tick_q + 32'h1;
        end
    end

    // Interrupt and bypass outputs
    wire mgm_act = |(evt_lo_q & ~mgm_lo_q) | |(evt_hi_q & ~mgm_hi_q);
    wire sec_act = |(evt_lo_q & ~sec_lo_q) | |(evt_hi_q & ~sec_hi_q);
    always_ff @(posedge clk) begin
        if (rst) begin
            mgmt_irq_n <= 1'b1;
            // Inactive level for the power-on polarity, which is active low
            second_irq <= 1'b1;
            bypass_oe  <= 1'b0;
        end else begin
            mgmt_irq_n <= ~(mgm_act & ctrl_q[CB_MGM_EN] & ~ctrl_q[CB_CLR]);
            second_irq <= (sec_act & ctrl_q[CB_SEC_EN] & ~ctrl_q[CB_CLR])
                          ^ ~ctrl_q[CB_POL];
            bypass_oe  <= ctrl_q[CB_BYPASS];
        end
    end

    // Open-drain lines only ever drive low
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_out    <= 1'b0;
            bypass_out <= 1'b0;
        end else begin
            sda_out    <= 1'b0;
            bypass_out <= 1'b0;
        end
    end
endmodule

/* verif/hmr_top_monitor.sv */
// Port checker for the monitor host register interface
`timescale 1ns/10ps
module hmr_top_monitor
    import hmr_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Parallel port
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [2:0] addr,
    input wire logic       rdata_oe,
    // Serial and control pins
    input wire logic       scl,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       mgmt_irq_n,
    input wire logic       second_irq,
    input wire logic       bypass_oe,
    input wire logic       conv_run,
    input wire logic [3:0] conv_item
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Decoded strobes as seen at the pins
    wire rd_sel = !cs_n && !rd_n && (addr == PORT_INDEX || addr == PORT_DATA);
    wire wr_act = !cs_n && !wr_n;

    // Read strobe held through the synchronizer, and a quiet strobe
    sequence s_held_read;
        rd_sel [*3];
    endsequence
    sequence s_idle_read;
        rd_n [*5];
    endsequence

    a_read_drives: assert property (s_held_read |-> ##[0:3] rdata_oe)
        else $error("held read not answered");
    a_idle_quiet: assert property (s_idle_read |-> !rdata_oe)
        else $error("data bus driven without read");
    a_oe_port: assert property (rdata_oe |-> addr == PORT_INDEX || addr == PORT_DATA)
        else $error("data bus driven for wrong port");
    a_item_order: assert property (conv_run && $past(conv_run) && $changed(conv_item) |->
        conv_item == (($past(conv_item) == 4'hA) ? 4'h0 : $past(conv_item) + 4'h1))
        else $error("item sequence broken");
    a_sda_pull: assert property (sda_oe |-> !sda_out)
        else $error("serial data driven high");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("serial data moved while clock high");
    a_reset_quiet: assert property ($fell(rst) |->
        mgmt_irq_n && second_irq && !bypass_oe && !conv_run)
        else $error("outputs active after reset");
    a_run_on_write: assert property ($rose(conv_run) |-> $past(wr_act, 3))
        else $error("converter started without write");
    a_bypass_write: assert property ($rose(bypass_oe) |-> $past(wr_act, 3))
        else $error("bypass pulled without write");
endmodule

bind hmr_top hmr_top_monitor mon_u (
    .clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .rdata_oe(rdata_oe), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
    .mgmt_irq_n(mgmt_irq_n), .second_irq(second_irq), .bypass_oe(bypass_oe),
    .conv_run(conv_run), .conv_item(conv_item)
);

/* verif/hmr_serial_host.sv */
// Two-wire bus master model facing the monitor's serial slave
`timescale 1ns/10ps
module hmr_serial_host (
    // Two-wire bus
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda_line
);
    localparam time Q = 100;  // Quarter of the 400 ns link period
    localparam time SKEW = 12;  // Keeps link edges off the bench clock edges

    // Idle bus: both released high, clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // One bit: data set mid-low, line sampled late in the high phase
    task automatic bit_io(input logic b, output logic s);
        #Q sda_m = b;
        #Q scl = 1'b1;
        #(Q * 2) s = sda_line;
        scl = 1'b0;
    endtask

    // Byte plus ninth bit; a released ninth bit is the master's NACK
    task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            r[i] = s;
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic start_c;
        #(Q + SKEW) sda_m = 1'b0;
        #(Q * 2) scl = 1'b0;
    endtask

    task automatic stop_c;
        #Q sda_m = 1'b0;
        #Q scl = 1'b1;
        #Q sda_m = 1'b1;
        #(Q * 2 - SKEW);
    endtask

    // Address, index, then optional data byte
    task automatic wrx(input logic [6:0] a, input logic [7:0] ix, input logic [7:0] d,
                       input logic with_data, output logic ack);
        logic [7:0] r;
        logic       k;
        start_c();
        byte_io({a, 1'b0}, r, ack);
        if (ack) begin
            byte_io(ix, r, k);
            ack = ack & k;
            if (with_data) begin
                byte_io(d, r, k);
                ack = ack & k;
            end
        end
        stop_c();
    endtask

    // Address then one returned byte from the current index
    task automatic rdx(input logic [6:0] a, output logic [7:0] q, output logic ack);
        logic [7:0] r;
        logic       k;
        start_c();
        byte_io({a, 1'b1}, r, ack);
        q = 8'h00;
        if (ack)
            byte_io(8'hFF, q, k);
        stop_c();
    endtask
endmodule

/* verif/hmr_top_tb.sv */
// Self-checking bench for the monitor host register interface
`timescale 1ns/10ps
module hmr_top_tb;
    import hmr_pkg::*;
    localparam logic ID_VAL = 1'b0;  // Arbitrary identity value
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cs_n = 1'b1;
    logic        rd_n = 1'b1;
    logic        wr_n = 1'b1;
    logic        id4 = 1'b0;
    logic        res_we = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  res_data = 8'h00;
    logic [3:0]  idl = 4'h0;
    logic [15:0] event_in = 16'h0000;
    logic [7:0]  rdata, q;
    logic [3:0]  conv_item, it;
    logic        rdata_oe, scl, sda_m, sda_out, sda_oe, mgmt_irq_n, second_irq;
    logic        bypass_out, bypass_oe, conv_run, ack;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          i;
    // Open-drain wire with pull-up: low if either party pulls
    wire         sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
    wire [7:0]   pins = {3'h0, bypass_out, mgmt_irq_n, second_irq, bypass_oe, conv_run};

    hmr_top #(.ITEM_CYC(20), .ID_BIT(ID_VAL)) dut_u (
        .clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .id_voltage_bits_low(idl), .id_voltage_bit4(id4), .event_in(event_in),
        .mgmt_irq_n(mgmt_irq_n), .second_irq(second_irq), .bypass_out(bypass_out),
        .bypass_oe(bypass_oe), .conv_run(conv_run), .conv_item(conv_item),
        .res_we(res_we), .res_data(res_data)
    );

    hmr_serial_host sh_u (.scl(scl), .sda_m(sda_m), .sda_line(sda_line));

    // 20 MHz clock
    always #25 clk = ~clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One parallel cycle; strobe held well past the two-flop synchronizer
    task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        cs_n <= 1'b0;
        wr_n <= ~w;
        rd_n <= w;
        repeat (6) @(posedge clk);
        #1 q = rdata;
        @(posedge clk);
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (5) @(posedge clk);
        cs_n <= 1'b1;
    endtask

    // Index first, then the data port
    task automatic wr(input logic [6:0] ix, input logic [7:0] d);
        bus(PORT_INDEX, 1'b1, {1'b0, ix});
        bus(PORT_DATA, 1'b1, d);
    endtask

    task automatic rchk(input logic [6:0] ix, input logic [7:0] e);
        bus(PORT_INDEX, 1'b1, {1'b0, ix});
        bus(PORT_DATA, 1'b0, 8'h00);
        chk(q, e);
    endtask

    task automatic ichk(input logic [7:0] e);
        bus(PORT_INDEX, 1'b0, 8'h00);
        chk(q, e);
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rchk(IDX_CTRL, RST_CTRL);
        rchk(IDX_EVT_LO, RST_ZERO);
        rchk(IDX_MGM_HI, RST_ZERO);
        rchk(IDX_SEC_HI, RST_SEC_HI);
        rchk(IDX_SADDR, {1'b0, RST_SADDR});
        for (i = 0; i < 2; i++) begin
            idl <= i[0] ? 4'h5 : 4'hA;
            id4 <= i[0];
            rchk(IDX_FANDIV, {RST_FANDIV, i[0] ? 4'h5 : 4'hA});
            rchk(IDX_IDENT, {ID_VAL, 6'h00, i[0]});
        end
        // Pair heads advance the index; a plain register does not
        wr(IDX_MGM_LO, 8'h3C);
        ichk(8'h44);
        wr(IDX_SEC_LO, 8'h3C);
        ichk(8'h46);
        wr(7'h7E, 8'h11);
        ichk(8'h7F);
        bus(PORT_DATA, 1'b1, 8'h22);
        ichk(8'h7F);
        rchk(7'h3E, 8'h11);
        ichk(8'h3E);
        // Code memory: 33 writes over both ports, the last lands on the top
        for (i = 0; i < 33; i++)
            bus(i[0] ? PORT_CODE_B : PORT_CODE_A, 1'b1, i[7:0]);
        rchk(7'h00, 8'h00);
        for (i = 1; i < 33; i++) begin
            bus(PORT_DATA, 1'b0, 8'h00);
            chk(q, i < 31 ? i[7:0] : 8'h20);
        end
        // Event with both outputs on, second one active high
        wr(IDX_CTRL, 8'h27);
        event_in <= 16'h0001;
        repeat (4) @(posedge clk);
        event_in <= 16'h0000;
        repeat (4) @(posedge clk);
        chk(pins, 8'h05);
        wr(IDX_CTRL, 8'h07);
        chk(pins, 8'h01);
        rchk(IDX_EVT_LO, 8'h01);
        bus(PORT_DATA, 1'b0, 8'h00);
        chk(q, 8'h00);
        ichk(8'h42);
        rchk(IDX_EVT_LO, 8'h00);
        wr(IDX_CTRL, 8'h49);
        chk(pins, 8'h0E);
        // Result written by the converter, read through the mirror
        wr(IDX_CTRL, 8'h01);
        it = conv_item;
        for (i = 0; i < 60 && conv_item === it; i++) begin
            @(posedge clk);
            #1;
        end
        it = conv_item;
        @(posedge clk);
        res_data <= 8'h5C;
        res_we <= 1'b1;
        @(posedge clk);
        res_we <= 1'b0;
        rchk(IDX_MIR_BASE + {3'h0, it}, 8'h5C);
        ichk({1'b0, IDX_MIR_BASE + {3'h0, it} + 7'h01});
        // Soft init keeps memories and the serial address
        wr(IDX_SADDR, 8'h33);
        wr(IDX_MGM_LO, 8'h5A);
        wr(IDX_CTRL, 8'h80);
        rchk(IDX_CTRL, RST_CTRL);
        rchk(IDX_MGM_LO, RST_ZERO);
        rchk(IDX_SADDR, 8'h33);
        rchk(7'h3E, 8'h11);
        rchk(IDX_MIR_BASE + {3'h0, it}, 8'h5C);
        // Serial write, then reads that must not move the index
        sh_u.wrx(7'h33, {1'b0, IDX_MGM_LO}, 8'h77, 1'b1, ack);
        chk({7'h00, ack}, 8'h01);
        rchk(IDX_MGM_LO, 8'h77);
        sh_u.wrx(7'h33, {1'b0, IDX_MGM_LO}, 8'h00, 1'b0, ack);
        sh_u.rdx(7'h33, q, ack);
        chk(q, 8'h77);
        sh_u.rdx(7'h33, q, ack);
        chk(q, 8'h77);
        ichk(8'h43);
        sh_u.wrx(7'h2D, {1'b0, IDX_MGM_LO}, 8'h00, 1'b1, ack);
        chk({7'h00, ack}, 8'h00);
        rchk(IDX_MGM_LO, 8'h77);
        // Busy flag while a serial frame runs; host only reads the index
        fork
            sh_u.wrx(7'h33, {1'b0, IDX_SEC_HI}, 8'h40, 1'b1, ack);
            begin
                repeat (40) @(posedge clk);
                ichk(8'hC4);
            end
        join
        ichk(8'h46);
        final_report();
    end
endmodule
